// *** core/esm_pkg.sv ***
// Package for the measurement sequencer: register map, fields, timing.
// Assumes a 50 MHz pclk and a 32-bit APB register bus.
package esm_pkg;

  // Register byte offsets
  localparam logic [11:0] ESM_CTRL_MEAS = 12'h000;
  localparam logic [11:0] ESM_CTRL_HUM  = 12'h004;
  localparam logic [11:0] ESM_CONFIG    = 12'h008;
  localparam logic [11:0] ESM_STATUS    = 12'h00C;
  localparam logic [11:0] ESM_RESET     = 12'h010;
  localparam logic [11:0] ESM_PRESS     = 12'h014;
  localparam logic [11:0] ESM_TEMP      = 12'h018;
  localparam logic [11:0] ESM_HUM       = 12'h01C;
  localparam logic [11:0] ESM_ADC_P     = 12'h020;
  localparam logic [11:0] ESM_ADC_T     = 12'h024;
  localparam logic [11:0] ESM_ADC_H     = 12'h028;

  // Field positions
  localparam int MODE_LSB  = 0;
  localparam int OSP_LSB   = 2;
  localparam int OST_LSB   = 5;
  localparam int FILT_LSB  = 2;
  localparam int SB_LSB    = 5;

  localparam logic [7:0]  SOFT_RESET_CODE = 8'hB6;
  localparam logic [19:0] SKIP_VALUE      = 20'h80000;
  localparam logic [15:0] HUM_SKIP_VALUE  = 16'h8000;

  // Timing
  localparam int CLK_MHZ          = 50;
  localparam int CONV_US          = 2;
  localparam int CONV_CYC         = CONV_US * CLK_MHZ;
  localparam int SB_HALF_MS_US    = 500;

  typedef enum logic [1:0] {
    MODE_SLEEP  = 2'b00,
    MODE_FORCED = 2'b01,
    MODE_NORMAL = 2'b11
  } esm_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_TEMP    = 3'b001,
    ST_PRESS   = 3'b010,
    ST_HUM     = 3'b011,
    ST_FILTER  = 3'b100,
    ST_STANDBY = 3'b101
  } esm_state_t;

  typedef struct packed {
    logic [19:0] press;
    logic [19:0] temp;
    logic [15:0] hum;
  } esm_sample_t;

endpackage

// *** core/esm_sequencer.sv ***
// Measurement sequencer with APB register file and IIR filter.
// Assumes raw converter samples arrive on adc_* ports, sync to pclk.
//
// Implementation choices: the address map and the APB interface to the registers.
module esm_sequencer
  import esm_pkg::*;
#(
  parameter int SB_UNIT_CYC = SB_HALF_MS_US * CLK_MHZ
) (
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Converter samples, 20-bit left aligned for p/t
  input  wire logic [19:0] adc_press,
  input  wire logic [19:0] adc_temp,
  input  wire logic [15:0] adc_hum,
  // Status
  output logic             measuring,
  output logic             data_valid
);

  logic        soft_rst_q;
  logic [1:0]  mode_q;
  logic [1:0]  pend_mode_q;
  logic        pend_q;
  logic [2:0]  osp_q, ost_q, osh_q, osh_act_q;
  logic [2:0]  filt_q, sb_q;
  logic        filt_init_q;
  esm_state_t  st_q;
  logic [31:0] cnt_q;
  esm_sample_t raw_q, out_q;
  logic [19:0] mem_p_q, mem_t_q;
  logic        busy_q;
  logic [31:0] prdata_q;
  logic        pready_q, pslverr_q, dv_q;

  wire logic wr_en = psel & penable & pwrite & pready_q;
  // Read data fetched in setup so it stands through the access
  wire logic rd_en = psel & ~penable & ~pwrite;
  wire logic rst_n = presetn; // Async part; soft reset is synchronous

  // Oversampling ratio, 0 means skipped
  // Codes above five saturate at sixteen
  function automatic logic [4:0] os_ratio(input logic [2:0] f);
    case (f)
      3'd0:    os_ratio = 5'd0;
      3'd1:    os_ratio = 5'd1;
      3'd2:    os_ratio = 5'd2;
      3'd3:    os_ratio = 5'd4;
      3'd4:    os_ratio = 5'd8;
      default: os_ratio = 5'd16;
    endcase
  endfunction

  // Conversion time in cycles for one channel
  function automatic logic [31:0] conv_len(input logic [2:0] f);
    conv_len = 32'(CONV_CYC) * {27'h0, os_ratio(f)};
  endfunction

  // Standby length: 0.5 ms scaled by the select code
  // Codes 6 and 7 fall between 0 and 1; table is not monotonic
  function automatic logic [31:0] sb_len(input logic [2:0] s);
    case (s)
      3'd0:    sb_len = 32'(SB_UNIT_CYC);
      3'd1:    sb_len = 32'(SB_UNIT_CYC) * 32'd125;
      3'd2:    sb_len = 32'(SB_UNIT_CYC) * 32'd250;
      3'd3:    sb_len = 32'(SB_UNIT_CYC) * 32'd500;
      3'd4:    sb_len = 32'(SB_UNIT_CYC) * 32'd1000;
      3'd5:    sb_len = 32'(SB_UNIT_CYC) * 32'd2000;
      3'd6:    sb_len = 32'(SB_UNIT_CYC) * 32'd20;
      default: sb_len = 32'(SB_UNIT_CYC) * 32'd40;
    endcase
  endfunction

  // Shift of the filter: coefficient 2^k, 0 means off
  function automatic logic [2:0] filt_k(input logic [2:0] f);
    case (f)
      3'd0:    filt_k = 3'd0;
      3'd1:    filt_k = 3'd1;
      3'd2:    filt_k = 3'd2;
      3'd3:    filt_k = 3'd3;
      default: filt_k = 3'd4;
    endcase
  endfunction

  // One IIR step
  // 25-bit sum holds old*15 plus a sample, no overflow
  function automatic logic [19:0] iir(input logic [19:0] old,
                                      input logic [19:0] smp,
                                      input logic [2:0]  k);
    logic [24:0] acc;
    acc = ({5'h0, old} << k) - {5'h0, old} + {5'h0, smp};
    iir = 20'(acc >> k);
  endfunction

  // Unfiltered resolution: keep 15+osrs top bits, all 20 for codes 5 to 7
  // Low bits zeroed, not rounded, so values never overshoot
  function automatic logic [19:0] trunc(input logic [19:0] v,
                                        input logic [2:0]  f);
    logic [19:0] m;
    m = 20'hFFFFF << (3'd5 - ((f > 3'd5) ? 3'd5 : f));
    trunc = v & m;
  endfunction

  wire logic [2:0] fk = filt_k(filt_q);

  // Soft reset pulse, full reset next edge
  // Bus side stays out of it so the write's access still completes
  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) soft_rst_q <= 1'b0;
    else soft_rst_q <= wr_en && paddr == ESM_RESET
                       && pwdata[7:0] == SOFT_RESET_CODE;
  end

  // Control registers
  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q      <= MODE_SLEEP;
      pend_mode_q <= MODE_SLEEP;
      pend_q      <= 1'b0;
      osp_q       <= 3'd0;
      ost_q       <= 3'd0;
      osh_q       <= 3'd0;
      filt_q      <= 3'd0;
      sb_q        <= 3'd0;
      filt_init_q <= 1'b1;
    end else if (soft_rst_q) begin
      mode_q      <= MODE_SLEEP;
      pend_mode_q <= MODE_SLEEP;
      pend_q      <= 1'b0;
      osp_q       <= 3'd0;
      ost_q       <= 3'd0;
      osh_q       <= 3'd0;
      filt_q      <= 3'd0;
      sb_q        <= 3'd0;
      filt_init_q <= 1'b1;
    end else begin
      // Forced ends in sleep; pending change applied at period end
      if (st_q == ST_FILTER && pend_q) begin
        mode_q <= pend_mode_q;
        pend_q <= 1'b0;
      end else if (st_q == ST_FILTER && mode_q == MODE_FORCED) begin
        mode_q <= MODE_SLEEP;
      end
      if (st_q == ST_FILTER) filt_init_q <= 1'b0;
      if (wr_en && paddr == ESM_CTRL_MEAS && !pend_q) begin
        osp_q <= pwdata[OSP_LSB +: 3];
        ost_q <= pwdata[OST_LSB +: 3];
        // Filter cycle counts as ended: a change queued there would
        // wait for a period that may never start
        if (busy_q && st_q != ST_FILTER) begin
          pend_mode_q <= pwdata[MODE_LSB +: 2];
          pend_q      <= 1'b1;
        end else begin
          mode_q <= pwdata[MODE_LSB +: 2];
        end
      end
      if (wr_en && paddr == ESM_CTRL_HUM && !pend_q)
        osh_q <= pwdata[2:0];
      if (wr_en && paddr == ESM_CONFIG) begin
        filt_q      <= pwdata[FILT_LSB +: 3];
        sb_q        <= pwdata[SB_LSB +: 3];
        filt_init_q <= 1'b1;
      end
    end
  end

  // Measurement sequencer
  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q      <= ST_IDLE;
      cnt_q     <= 32'd0;
      busy_q    <= 1'b0;
      raw_q     <= '0;
      osh_act_q <= 3'd0;
    end else if (soft_rst_q) begin
      st_q      <= ST_IDLE;
      cnt_q     <= 32'd0;
      busy_q    <= 1'b0;
      raw_q     <= '0;
      osh_act_q <= 3'd0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          // Sleep performs nothing
          // Humidity setting frozen for the period; later writes wait, or are dropped while pend_q is set
          if (mode_q == MODE_FORCED || mode_q == MODE_NORMAL) begin
            st_q      <= ST_TEMP;
            busy_q    <= 1'b1;
            cnt_q     <= conv_len(ost_q);
            osh_act_q <= osh_q;
          end
        end
        ST_TEMP: begin
          if (cnt_q == 32'd0) begin
            raw_q.temp <= adc_temp;
            st_q       <= ST_PRESS;
            cnt_q      <= conv_len(osp_q);
          end else cnt_q <= cnt_q - 32'd1;
        end
        ST_PRESS: begin
          if (cnt_q == 32'd0) begin
            raw_q.press <= adc_press;
            st_q        <= ST_HUM;
            cnt_q       <= conv_len(osh_act_q);
          end else cnt_q <= cnt_q - 32'd1;
        end
        ST_HUM: begin
          if (cnt_q == 32'd0) begin
            raw_q.hum <= adc_hum;
            st_q      <= ST_FILTER;
          end else cnt_q <= cnt_q - 32'd1;
        end
        ST_FILTER: begin
          busy_q <= 1'b0;
          if (mode_q == MODE_NORMAL && !pend_q) begin
            st_q  <= ST_STANDBY;
            cnt_q <= sb_len(sb_q);
          // Queued normal enters standby directly, like a running normal
          end else if (pend_q && pend_mode_q == MODE_NORMAL) begin
            st_q  <= ST_STANDBY;
            cnt_q <= sb_len(sb_q);
          end else begin
            st_q <= ST_IDLE;
          end
        end
        ST_STANDBY: begin
          // Mode changes in standby take effect at once
          if (mode_q != MODE_NORMAL) st_q <= ST_IDLE;
          else if (cnt_q == 32'd0) st_q <= ST_IDLE;
          else cnt_q <= cnt_q - 32'd1;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Filter and output registers
  // Pressure and temperature each own their memory; a skipped channel leaves it alone
  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      mem_p_q <= 20'h0;
      mem_t_q <= 20'h0;
      out_q   <= {SKIP_VALUE, SKIP_VALUE, HUM_SKIP_VALUE};
      dv_q    <= 1'b0;
    end else if (soft_rst_q) begin
      mem_p_q <= 20'h0;
      mem_t_q <= 20'h0;
      out_q   <= {SKIP_VALUE, SKIP_VALUE, HUM_SKIP_VALUE};
      dv_q    <= 1'b0;
    end else if (st_q == ST_FILTER) begin
      dv_q <= 1'b1;
      if (osp_q == 3'd0) begin
        out_q.press <= SKIP_VALUE;
      end else if (fk == 3'd0) begin
        out_q.press <= trunc(raw_q.press, osp_q);
        mem_p_q     <= raw_q.press;
      end else if (filt_init_q) begin
        out_q.press <= raw_q.press;
        mem_p_q     <= raw_q.press;
      end else begin
        out_q.press <= iir(mem_p_q, raw_q.press, fk);
        mem_p_q     <= iir(mem_p_q, raw_q.press, fk);
      end
      if (ost_q == 3'd0) begin
        out_q.temp <= SKIP_VALUE;
      end else if (fk == 3'd0) begin
        out_q.temp <= trunc(raw_q.temp, ost_q);
        mem_t_q    <= raw_q.temp;
      end else if (filt_init_q) begin
        out_q.temp <= raw_q.temp;
        mem_t_q    <= raw_q.temp;
      end else begin
        out_q.temp <= iir(mem_t_q, raw_q.temp, fk);
        mem_t_q    <= iir(mem_t_q, raw_q.temp, fk);
      end
      // Humidity bypasses the filter entirely
      out_q.hum <= (osh_act_q == 3'd0) ? HUM_SKIP_VALUE
                                       : raw_q.hum;
    end
  end

  // APB read side; one wait-free access phase
  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q  <= 32'h0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= psel & ~penable;
      pslverr_q <= 1'b0;
      if (rd_en) begin
        if (paddr == ESM_CTRL_MEAS)
          prdata_q <= {24'h0, ost_q, osp_q, mode_q};
        else if (paddr == ESM_CTRL_HUM)
          prdata_q <= {29'h0, osh_q};
        else if (paddr == ESM_CONFIG)
          prdata_q <= {24'h0, sb_q, filt_q, 2'b00};
        else if (paddr == ESM_STATUS)
          prdata_q <= {29'h0, pend_q, dv_q, busy_q};
        else if (paddr == ESM_RESET)
          prdata_q <= 32'h0;
        else if (paddr == ESM_PRESS)
          prdata_q <= {12'h0, out_q.press};
        else if (paddr == ESM_TEMP)
          prdata_q <= {12'h0, out_q.temp};
        else if (paddr == ESM_HUM)
          prdata_q <= {16'h0, out_q.hum};
        else if (paddr == ESM_ADC_P)
          prdata_q <= {12'h0, mem_p_q};
        else if (paddr == ESM_ADC_T)
          prdata_q <= {12'h0, mem_t_q};
        else if (paddr == ESM_ADC_H)
          prdata_q <= {16'h0, raw_q.hum};
        else begin
          prdata_q  <= 32'h0;
          pslverr_q <= 1'b1;
        end
      end else if (psel & ~penable & pwrite) begin
        // Writes land in the control block; here only bad addresses
        prdata_q <= 32'h0;
        if (paddr > ESM_ADC_H || paddr[1:0] != 2'b00)
          pslverr_q <= 1'b1;
      end
    end
  end

  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign measuring  = busy_q;
  assign data_valid = dv_q;

endmodule

// *** sim/esm_monitor.sv ***
// Port checker for the measurement sequencer.
// Assumes one pclk domain; bound onto esm_sequencer below.
module esm_monitor
  import esm_pkg::*;
#(
  parameter int SB_UNIT_CYC = 4
) (
  // APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Status
  input wire logic        measuring,
  input wire logic        data_valid
);
  logic       soft_w;
  logic [1:0] soft_q;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  assign soft_w = psel && penable && pready && pwrite &&
                  paddr == ESM_RESET && pwdata[7:0] == SOFT_RESET_CODE;

  // Soft reset may end a period without fresh data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      soft_q <= 2'b00;
    else
      soft_q <= {soft_q[0], soft_w};
  end

  ready_pulse_a:
    assert property (pready |=> !pready) else $error("pready too long");
  ready_access_a:
    assert property (psel && penable |-> pready) else $error("no pready");
  ready_cause_a:
    assert property (pready |-> psel && penable) else $error("stray pready");
  mapped_ok_a:
    assert property (psel && penable && paddr <= ESM_ADC_H &&
      paddr[1:0] == 2'b00 |-> !pslverr) else $error("mapped slverr");
  unmapped_read_a:
    assert property (psel && penable && !pwrite && paddr > ESM_ADC_H
      |-> pslverr && prdata == 32'h0) else $error("unmapped read");
  sleep_at_start_a:
    assert property ($rose(presetn) |-> (!measuring && !data_valid) [*2])
      else $error("not asleep after reset");
  period_min_a:
    assert property ($rose(measuring) |-> measuring [*3])
      else $error("measuring too short");
  done_valid_a:
    assert property ($fell(measuring) && soft_q == 2'b00 && !soft_w
      |-> ##[0:1] data_valid) else $error("no data after period");
  soft_reset_a:
    assert property (soft_w |-> ##2 (!measuring && !data_valid))
      else $error("soft reset missed");
endmodule

bind esm_sequencer esm_monitor #(.SB_UNIT_CYC(SB_UNIT_CYC)) u_esm_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .measuring(measuring),
  .data_valid(data_valid)
);

// *** sim/esm_host.sv ***
// Host model: APB master that configures the sequencer.
// Assumes the bench calls xfer; one transfer at a time.
module esm_host (
  // Clock and answer
  input  wire logic        pclk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // Request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
  end

  // Request held until pready is seen; no fixed latency assumed
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// *** sim/esm_sequencer_test.sv ***
// Self-checking bench for the measurement sequencer.
// Assumes short standby units (SB) to keep the run brief.
module esm_sequencer_test
  import esm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SB = 4;
  localparam int TSB [8] = '{1, 125, 250, 500, 1000, 2000, 20, 40};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        measuring, data_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [19:0] msk;
  esm_sample_t smp;
  int          err_total, total_checks, cnt, n;

  esm_sequencer #(.SB_UNIT_CYC(SB)) u_esm_sequencer (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .adc_press(smp.press),
    .adc_temp(smp.temp), .adc_hum(smp.hum), .measuring(measuring),
    .data_valid(data_valid));
  esm_host u_esm_host (
    .pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata));

  initial pclk = 1'b0;
  always #10 pclk = ~pclk;

  task automatic report_and_stop;
    if (err_total == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_esm_host.xfer(1'b1, a, d, rd, er);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    u_esm_host.xfer(1'b0, a, 32'h0, rd, er);
    chk(rd, exp);
  endtask
  task automatic wait_meas(input logic lvl);
    cnt = 0;
    while (measuring !== lvl && cnt < 20000) begin
      @(posedge pclk);
      cnt++;
    end
    if (cnt == 20000) chk(32'h0, 32'h1);
  endtask
  task automatic forced(input logic [2:0] op, input logic [2:0] ot);
    wr(ESM_CTRL_MEAS, {24'h0, ot, op, 2'b01});
    wait_meas(1'b1);
    wait_meas(1'b0);
  endtask

  initial begin
    repeat (100000) @(posedge pclk);
    err_total++;
    report_and_stop;
  end

  initial begin
    presetn = 1'b0;
    err_total = 0;
    total_checks = 0;
    smp = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdc(ESM_STATUS, 32'h0);
    rdc(ESM_PRESS, 32'h80000);
    rdc(12'h0FC, 32'h0);
    chk({31'h0, er}, 32'h1);
    wr(ESM_CONFIG, 32'hE0);
    rdc(ESM_CONFIG, 32'hE0);
    smp <= {20'hABCDE, 20'h12345, 16'h5A5A};
    for (int k = 1; k <= 5; k++) begin
      msk = 20'hFFFFF << (5 - k);
      wr(ESM_CTRL_HUM, k);
      forced(3'(k), 3'(k));
      rdc(ESM_PRESS, {12'h0, 20'hABCDE & msk});
      rdc(ESM_TEMP, {12'h0, 20'h12345 & msk});
      rdc(ESM_HUM, 32'h5A5A);
    end
    wr(ESM_CTRL_HUM, 32'h0);
    forced(3'h0, 3'h0);
    rdc(ESM_PRESS, 32'h80000);
    rdc(ESM_HUM, 32'h8000);
    wr(ESM_CTRL_HUM, 32'h1);
    for (int c = 1; c <= 4; c++) begin
      n = 2 ** c;
      wr(ESM_CONFIG, c << 2);
      smp <= {20'h00003, 20'h00003, 16'h1111};
      forced(3'h1, 3'h1);
      rdc(ESM_PRESS, 32'h3);
      smp <= {20'hF0003, 20'hF0003, 16'h2222};
      forced(3'h1, 3'h1);
      rdc(ESM_PRESS, (3 * (n - 1) + 32'hF0003) / n);
      rdc(ESM_HUM, 32'h2222);
    end
    forced(3'h1, 3'h0);
    rdc(ESM_TEMP, 32'h80000);
    smp <= {20'hF0003, 20'h00003, 16'h2222};
    forced(3'h1, 3'h1);
    rdc(ESM_TEMP, (32'hF003 * 15 + 3) / 16);
    wr(ESM_CTRL_HUM, 32'h0);
    wr(ESM_CTRL_MEAS, 32'h23);
    for (int s = 0; s < 8; s++) begin
      wr(ESM_CONFIG, s << 5);
      wait_meas(1'b1);
      wait_meas(1'b0);
      wait_meas(1'b1);
      n = TSB[s] * SB;
      chk({31'h0, cnt >= n - 1 && cnt <= n + 3}, 32'h1);
    end
    smp <= {20'hF0003, 20'h54321, 16'h2222};
    wait_meas(1'b0);
    wait_meas(1'b1);
    wait_meas(1'b0);
    rdc(ESM_TEMP, 32'h54320);
    wait_meas(1'b1);
    wr(ESM_CTRL_MEAS, 32'h20);
    wr(ESM_CTRL_HUM, 32'h5);
    wr(ESM_CTRL_MEAS, 32'h23);
    rdc(ESM_STATUS, 32'h7);
    wait_meas(1'b0);
    rdc(ESM_CTRL_HUM, 32'h0);
    rdc(ESM_CTRL_MEAS, 32'h20);
    repeat (200) @(posedge pclk);
    rdc(ESM_STATUS, 32'h2);
    wr(ESM_RESET, 32'hB6);
    rdc(ESM_STATUS, 32'h0);
    rdc(ESM_CONFIG, 32'h0);
    rdc(ESM_TEMP, 32'h80000);
    wr(ESM_CTRL_MEAS, 32'h22);
    repeat (300) @(posedge pclk);
    rdc(ESM_STATUS, 32'h0);
    rdc(ESM_CTRL_MEAS, 32'h22);
    wr(ESM_CONFIG, 32'hE0);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc(ESM_CONFIG, 32'h0);
    rdc(ESM_CTRL_MEAS, 32'h0);
    report_and_stop;
  end
endmodule
